// [common/rcf_pkg.sv]
// Shared constants and carriers for the reset-cause flag logic
package rcf_pkg;

    // ==========================================================
    // Register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_CAUSE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_PROT_CTRL = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_SEG_LO = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_SEG_HI = 4'h6;
    localparam logic [DATA_W-1:0] UNMAPPED_DATA = 16'h0000;

    // ==========================================================
    // Reset-cause flag positions
    localparam int BIT_TRAP = 15;
    localparam int BIT_ILLEGAL = 14;
    localparam int BIT_CFG = 9;
    localparam int BIT_PIN = 7;
    localparam int BIT_SOFT = 6;
    localparam int BIT_WDT = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_IDLE = 2;
    localparam int BIT_BOR = 1;
    localparam int BIT_POR = 0;

    // ==========================================================
    // Interrupt status layout
    localparam int IRQ_W = 4;
    localparam int IRQ_RESET = 0;
    localparam int IRQ_SECURE = 1;
    localparam int IRQ_TRAP = 2;
    localparam int IRQ_WDT = 3;

    // ==========================================================
    // Core-facing constants
    localparam int PC_W = 24;
    localparam logic [PC_W-1:0] RESET_VECTOR = 24'h000000;
    localparam int SEG_SHIFT = 8;
    localparam int TRAP_LVL_W = 4;
    localparam logic [TRAP_LVL_W-1:0] HARD_TRAP_LO = 4'hD;
    localparam logic [TRAP_LVL_W-1:0] HARD_TRAP_HI = 4'hF;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        logic por_event;
        logic brownout_reset;
        logic pin_reset;
        logic reset_instr;
        logic illegal_opcode;
        logic config_mismatch;
        logic watchdog_timeout;
        logic watchdog_clear_instr;
        logic sleep_instr;
        logic idle_instr;
        logic core_asleep;
    } cause_evt_s;

endpackage

// [hdl/reset_cause_flag_logic.sv]
// Reset-cause detection, flag register and post-reset fetch address
// ==========================================================
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
module reset_cause_flag_logic
    import rcf_pkg::*;
#(
    parameter int NUM_WREG = 16,
    parameter int SP_INDEX = 15
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire bus_req_s bus,
    output logic [DATA_W-1:0] rd_data,
    input wire cause_evt_s evt,
    input wire logic wreg_wr,
    input wire logic [$clog2(NUM_WREG)-1:0] wreg_wr_idx,
    input wire logic ptr_use,
    input wire logic [$clog2(NUM_WREG)-1:0] ptr_idx,
    input wire logic program_flow_change,
    input wire logic vector_flow_change,
    input wire logic [PC_W-1:0] flow_target,
    input wire logic trap_take,
    input wire logic [TRAP_LVL_W-1:0] trap_level,
    input wire logic trap_exit,
    output logic device_reset,
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    output logic irq
);

    localparam int IDX_W = $clog2(NUM_WREG);
    localparam logic [IDX_W-1:0] SP_IDX = IDX_W'(SP_INDEX);

    if (NUM_WREG < 2 || SP_INDEX >= NUM_WREG || SP_INDEX < 0)
    begin : g_shape_check
        $error("reset_cause_flag_logic: bad register file shape");
    end

    // ==========================================================
    // Cause detection
    logic uninit_hit;
    logic flow_change;
    logic seg_hit;
    logic secure_hit;
    logic hard_trap;
    logic trap_conflict;
    logic wdt_reset;
    logic reset_now;

    logic [NUM_WREG-1:0] wvalid_r;
    logic [NUM_WREG-1:0] wvalid_nxt;
    logic prot_en_r;
    logic [DATA_W-1:0] seg_lo_r;
    logic [DATA_W-1:0] seg_hi_r;
    logic trap_busy_r;
    logic trap_busy_nxt;
    logic [TRAP_LVL_W-1:0] trap_lvl_r;
    logic [TRAP_LVL_W-1:0] trap_lvl_nxt;
    logic [DATA_W-1:0] tgt_seg;

    always_comb
    begin
        uninit_hit = ptr_use && !wvalid_r[ptr_idx];
        flow_change = program_flow_change || vector_flow_change;
        tgt_seg = flow_target[PC_W-1:SEG_SHIFT];
        // Segment base stays open as the only legal entry point
        seg_hit = (tgt_seg >= seg_lo_r) && (tgt_seg <= seg_hi_r)
            && (flow_target != {seg_lo_r, SEG_SHIFT'(0)});
        secure_hit = prot_en_r && flow_change && seg_hit;
        hard_trap = (trap_level >= HARD_TRAP_LO) && (trap_level <= HARD_TRAP_HI);
        trap_conflict = trap_take && trap_busy_r && hard_trap
            && (trap_level < trap_lvl_r);
        // Expiry in a power-save state sets the flag but does not reset the device
        wdt_reset = evt.watchdog_timeout && !evt.core_asleep;
        reset_now = uninit_hit || secure_hit || trap_conflict || wdt_reset
            || evt.illegal_opcode || evt.config_mismatch || evt.reset_instr
            || evt.pin_reset || evt.por_event || evt.brownout_reset;
    end

    // ==========================================================
    // Working register validity and trap nesting
    always_comb
    begin
        wvalid_nxt = wvalid_r;
        trap_busy_nxt = trap_busy_r;
        trap_lvl_nxt = trap_lvl_r;
        if (reset_now)
        begin
            wvalid_nxt = '0;
            wvalid_nxt[SP_IDX] = 1'b1;
            trap_busy_nxt = 1'b0;
            trap_lvl_nxt = '0;
        end
        else
        begin
            if (wreg_wr)
                wvalid_nxt[wreg_wr_idx] = 1'b1;
            if (trap_take)
            begin
                trap_busy_nxt = 1'b1;
                trap_lvl_nxt = trap_level;
            end
            else if (trap_exit)
                trap_busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wvalid_r <= NUM_WREG'(1) << SP_INDEX;
            trap_busy_r <= 1'b0;
            trap_lvl_r <= '0;
        end
        else if (ce)
        begin
            wvalid_r <= wvalid_nxt;
            trap_busy_r <= trap_busy_nxt;
            trap_lvl_r <= trap_lvl_nxt;
        end
    end

    // ==========================================================
    // Reset-cause flags
    logic [DATA_W-1:0] cause_r;
    logic [DATA_W-1:0] cause_nxt;
    logic cause_wr;
    logic any_power;

    // Unimplemented positions read as zero and ignore writes
    localparam logic [DATA_W-1:0] CAUSE_MASK = (DATA_W'(1) << BIT_TRAP)
        | (DATA_W'(1) << BIT_ILLEGAL) | (DATA_W'(1) << BIT_CFG) | (DATA_W'(1) << BIT_PIN)
        | (DATA_W'(1) << BIT_SOFT) | (DATA_W'(1) << BIT_WDT) | (DATA_W'(1) << BIT_SLEEP)
        | (DATA_W'(1) << BIT_IDLE) | (DATA_W'(1) << BIT_BOR) | (DATA_W'(1) << BIT_POR);

    always_comb
    begin
        cause_wr = bus.wr && (bus.addr == ADDR_CAUSE);
        any_power = evt.por_event || evt.brownout_reset;
        cause_nxt = cause_r;
        if (cause_wr)
            cause_nxt = bus.wdata;
        if (any_power)
        begin
            cause_nxt[BIT_TRAP] = 1'b0;
            cause_nxt[BIT_ILLEGAL] = 1'b0;
            cause_nxt[BIT_CFG] = 1'b0;
            cause_nxt[BIT_SOFT] = 1'b0;
            cause_nxt[BIT_WDT] = 1'b0;
            cause_nxt[BIT_SLEEP] = 1'b0;
            cause_nxt[BIT_IDLE] = 1'b0;
        end
        if (evt.por_event)
            cause_nxt[BIT_PIN] = 1'b0;
        if (evt.sleep_instr || evt.idle_instr || evt.watchdog_clear_instr)
            cause_nxt[BIT_WDT] = 1'b0;
        // Hardware sets land after every clear so an event is never lost
        if (trap_conflict)
            cause_nxt[BIT_TRAP] = 1'b1;
        if (evt.illegal_opcode || uninit_hit || secure_hit)
            cause_nxt[BIT_ILLEGAL] = 1'b1;
        if (evt.config_mismatch)
            cause_nxt[BIT_CFG] = 1'b1;
        if (evt.pin_reset)
            cause_nxt[BIT_PIN] = 1'b1;
        if (evt.reset_instr)
            cause_nxt[BIT_SOFT] = 1'b1;
        if (evt.watchdog_timeout)
            cause_nxt[BIT_WDT] = 1'b1;
        if (evt.sleep_instr)
            cause_nxt[BIT_SLEEP] = 1'b1;
        if (evt.idle_instr)
            cause_nxt[BIT_IDLE] = 1'b1;
        if (any_power)
            cause_nxt[BIT_BOR] = 1'b1;
        if (evt.por_event)
            cause_nxt[BIT_POR] = 1'b1;
        cause_nxt = cause_nxt & CAUSE_MASK;
    end

    // Deliberately outside rst: rst leaves it; power events, bus writes and watchdog-clear or power-save instructions change it
    always_ff @(posedge ref_clk)
    begin
        if (ce)
            cause_r <= cause_nxt;
    end

    // ==========================================================
    // Control registers, interrupts and read port
    logic [IRQ_W-1:0] ist_r;
    logic [IRQ_W-1:0] ist_nxt;
    logic [IRQ_W-1:0] ien_r;
    logic [IRQ_W-1:0] ien_nxt;
    logic prot_en_nxt;
    logic [DATA_W-1:0] seg_lo_nxt;
    logic [DATA_W-1:0] seg_hi_nxt;
    logic [DATA_W-1:0] rd_nxt;
    logic [IRQ_W-1:0] ev_vec;

    always_comb
    begin
        ev_vec = '0;
        ev_vec[IRQ_RESET] = reset_now;
        ev_vec[IRQ_SECURE] = secure_hit;
        ev_vec[IRQ_TRAP] = trap_conflict;
        ev_vec[IRQ_WDT] = evt.watchdog_timeout;
        ist_nxt = ist_r;
        ien_nxt = ien_r;
        prot_en_nxt = prot_en_r;
        seg_lo_nxt = seg_lo_r;
        seg_hi_nxt = seg_hi_r;
        if (bus.wr)
        begin
            if (bus.addr == ADDR_IRQ_CLR)
                ist_nxt = ist_r & ~bus.wdata[IRQ_W-1:0];
            else if (bus.addr == ADDR_IRQ_EN)
                ien_nxt = bus.wdata[IRQ_W-1:0];
            else if (bus.addr == ADDR_PROT_CTRL)
                prot_en_nxt = bus.wdata[0];
            else if (bus.addr == ADDR_SEG_LO)
                seg_lo_nxt = bus.wdata;
            else if (bus.addr == ADDR_SEG_HI)
                seg_hi_nxt = bus.wdata;
        end
        ist_nxt = ist_nxt | ev_vec;
        rd_nxt = UNMAPPED_DATA;
        if (bus.rd)
        begin
            if (bus.addr == ADDR_CAUSE)
                rd_nxt = cause_r;
            else if (bus.addr == ADDR_IRQ_STAT)
                rd_nxt = DATA_W'(ist_r);
            else if (bus.addr == ADDR_IRQ_EN)
                rd_nxt = DATA_W'(ien_r);
            else if (bus.addr == ADDR_PROT_CTRL)
                rd_nxt = DATA_W'(prot_en_r);
            else if (bus.addr == ADDR_SEG_LO)
                rd_nxt = seg_lo_r;
            else if (bus.addr == ADDR_SEG_HI)
                rd_nxt = seg_hi_r;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ist_r <= '0;
            ien_r <= '0;
            prot_en_r <= 1'b0;
            seg_lo_r <= 16'h0000;
            seg_hi_r <= 16'h0000;
            rd_data <= UNMAPPED_DATA;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            ist_r <= ist_nxt;
            ien_r <= ien_nxt;
            prot_en_r <= prot_en_nxt;
            seg_lo_r <= seg_lo_nxt;
            seg_hi_r <= seg_hi_nxt;
            rd_data <= rd_nxt;
            irq <= |(ist_nxt & ien_nxt);
        end
    end

    // ==========================================================
    // Device reset and fetch restart
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            device_reset <= 1'b0;
            pc_load <= 1'b1;
            pc_value <= RESET_VECTOR;
        end
        else if (ce)
        begin
            device_reset <= reset_now;
            pc_load <= reset_now;
            pc_value <= RESET_VECTOR;
        end
    end

    // ==========================================================
    // Checks
    uninit_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && ptr_use && !wvalid_r[ptr_idx] |=> device_reset)
        else $error("uninitialised pointer use did not reset");
    wreg_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && reset_now |=> wvalid_r == (NUM_WREG'(1) << SP_INDEX))
        else $error("working registers not invalidated on reset");
    secure_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && secure_hit |=> device_reset && cause_r[BIT_ILLEGAL])
        else $error("protected segment entry did not reset");
    trap_conflict_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && trap_conflict |=> cause_r[BIT_TRAP] && device_reset)
        else $error("trap conflict not recorded");
    wdt_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && evt.watchdog_clear_instr && !evt.watchdog_timeout |=> !cause_r[BIT_WDT])
        else $error("watchdog flag not cleared");
    sw_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && cause_wr && !reset_now && !flow_change && !evt.sleep_instr
        && !evt.idle_instr && !evt.watchdog_clear_instr && !evt.watchdog_timeout
        |=> cause_r == ($past(bus.wdata) & CAUSE_MASK))
        else $error("software write to cause flags lost");
    flags_keep_a: assert property (@(posedge ref_clk)
        rst && ce && !cause_wr && $stable(evt) && evt == '0 |=> $stable(cause_r))
        else $error("cause flags disturbed by system reset");
    pin_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && evt.pin_reset |=> cause_r[BIT_PIN] ##1 (cause_r[BIT_PIN] || $past(cause_wr)
        || $past(evt.por_event) || !$past(ce)))
        else $error("pin reset flag not held");
    fetch_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        pc_load |-> pc_value == RESET_VECTOR && (device_reset || $past(rst)))
        else $error("fetch restart not at reset vector");

endmodule

// [bench/core_model.sv]
// Processor-core model driving register, pointer, flow and trap strobes
module core_model
    import rcf_pkg::*;
(
    input wire logic ref_clk,
    output logic wreg_wr,
    output logic [3:0] wreg_wr_idx,
    output logic ptr_use,
    output logic [3:0] ptr_idx,
    output logic program_flow_change,
    output logic vector_flow_change,
    output logic [PC_W-1:0] flow_target,
    output logic trap_take,
    output logic [TRAP_LVL_W-1:0] trap_level,
    output logic trap_exit
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Idle state
    initial
    begin
        {wreg_wr, ptr_use, program_flow_change, vector_flow_change} = 4'h0;
        {trap_take, trap_exit} = 2'h0;
        wreg_wr_idx = 4'h0;
        ptr_idx = 4'h0;
        flow_target = 24'h000000;
        trap_level = 4'h0;
    end

    // ==========================================================
    // One-cycle strobe: 0 reg write, 1 pointer use, 2 branch, 3 vector,
    // 4 trap taken, 5 trap exit
    task automatic op(input int k, input logic [PC_W-1:0] v);
        @(posedge ref_clk);
        wreg_wr <= (k == 0);
        ptr_use <= (k == 1);
        program_flow_change <= (k == 2);
        vector_flow_change <= (k == 3);
        trap_take <= (k == 4);
        trap_exit <= (k == 5);
        wreg_wr_idx <= v[3:0];
        ptr_idx <= v[3:0];
        flow_target <= v;
        trap_level <= v[3:0];
        @(posedge ref_clk);
        {wreg_wr, ptr_use, program_flow_change, vector_flow_change} <= 4'h0;
        {trap_take, trap_exit} <= 2'h0;
        // Released qualifiers must not keep looking valid
        wreg_wr_idx <= ~v[3:0];
        ptr_idx <= ~v[3:0];
        flow_target <= ~v;
        trap_level <= ~v[3:0];
    endtask
endmodule

// [bench/test_reset_cause_flag_logic.sv]
// Self-checking testbench for the reset-cause flag logic
module test_reset_cause_flag_logic import rcf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk, rst, ce, asleep, device_reset, pc_load, irq;
    logic wreg_wr, ptr_use, program_flow_change, vector_flow_change, trap_take, trap_exit;
    logic [3:0] wreg_wr_idx, ptr_idx;
    logic [TRAP_LVL_W-1:0] trap_level;
    logic [PC_W-1:0] flow_target, pc_value;
    logic [DATA_W-1:0] rd_data;
    bus_req_s bus;
    cause_evt_s evt;
    int err_total, num_checks, cycles;

    reset_cause_flag_logic i_reset_cause_flag_logic (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .bus(bus), .rd_data(rd_data), .evt(evt), .wreg_wr(wreg_wr), .wreg_wr_idx(wreg_wr_idx),
        .ptr_use(ptr_use), .ptr_idx(ptr_idx), .program_flow_change(program_flow_change),
        .vector_flow_change(vector_flow_change), .flow_target(flow_target),
        .trap_take(trap_take), .trap_level(trap_level), .trap_exit(trap_exit),
        .device_reset(device_reset), .pc_load(pc_load), .pc_value(pc_value), .irq(irq));

    core_model i_core_model (.ref_clk(ref_clk), .wreg_wr(wreg_wr), .wreg_wr_idx(wreg_wr_idx),
        .ptr_use(ptr_use), .ptr_idx(ptr_idx), .program_flow_change(program_flow_change),
        .vector_flow_change(vector_flow_change), .flow_target(flow_target),
        .trap_take(trap_take), .trap_level(trap_level), .trap_exit(trap_exit));

    // ==========================================================
    // Clock, hang guard and verdict
    initial
    begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp, input string m);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, seen, exp);
        end
    endtask

    // ==========================================================
    // Bus, event and core helpers
    task automatic bw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge ref_clk);
        bus.wr <= 1'h0;
    endtask

    task automatic br(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string m);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
        @(posedge ref_clk);
        bus.rd <= 1'h0;
        #1;
        check(24'(rd_data), 24'(exp), m);
    endtask

    // Event order: por, bor, pin, reset instr, opcode, config, wdt, wdt clear, sleep, idle
    task automatic ev(input logic [10:0] m, input logic rst_exp);
        @(posedge ref_clk);
        evt <= cause_evt_s'({m[10:1], asleep});
        @(posedge ref_clk);
        evt <= cause_evt_s'({10'h000, asleep});
        #1;
        check(24'(device_reset), 24'(rst_exp), "reset pulse on event");
    endtask

    task automatic cop(input int k, input logic [PC_W-1:0] v, input logic rst_exp);
        i_core_model.op(k, v);
        #1;
        check(24'(device_reset), 24'(rst_exp), "reset pulse on core op");
        check(24'(pc_load), 24'(rst_exp), "fetch reload");
    endtask

    task automatic tick2;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_power;
        ev(11'h400, 1'h1);
        br(ADDR_CAUSE, 16'h0003, "power-on flags");
        br(ADDR_IRQ_EN, 16'h0000, "enable after reset");
        br(4'hF, UNMAPPED_DATA, "unmapped read");
        bw(ADDR_CAUSE, 16'hC2DF);
        br(ADDR_CAUSE, 16'hC2DF, "software set");
        ev(11'h200, 1'h1);
        br(ADDR_CAUSE, 16'h0083, "brown-out flags");
        ev(11'h400, 1'h1);
        br(ADDR_CAUSE, 16'h0003, "power-on clears pin flag");
    endtask

    task automatic t_events;
        logic [10:0] m [7] = '{11'h100, 11'h080, 11'h040, 11'h020, 11'h010, 11'h004, 11'h002};
        int b [7] = '{BIT_PIN, BIT_SOFT, BIT_ILLEGAL, BIT_CFG, BIT_WDT, BIT_SLEEP, BIT_IDLE};
        for (int i = 0; i < 7; i++)
        begin
            bw(ADDR_CAUSE, 16'h0000);
            ev(m[i], i < 5);
            br(ADDR_CAUSE, 16'h0001 << b[i], "event flag");
        end
    endtask

    task automatic t_wdt;
        bw(ADDR_CAUSE, 16'h0000);
        asleep = 1'h1;
        // Expiry while asleep sets the flag but gives no reset
        ev(11'h010, 1'h0);
        br(ADDR_CAUSE, 16'h0010, "expiry while asleep");
        asleep = 1'h0;
        ev(11'h008, 1'h0);
        br(ADDR_CAUSE, 16'h0000, "watchdog clear");
        ev(11'h010, 1'h1);
        ev(11'h004, 1'h0);
        br(ADDR_CAUSE, 16'h0008, "power save clears expiry");
        ev(11'h100, 1'h1);
        br(ADDR_CAUSE, 16'h0088, "flags kept over pin reset");
    endtask

    task automatic t_wreg;
        bw(ADDR_CAUSE, 16'h0000);
        cop(1, 24'h00000F, 1'h0);
        cop(1, 24'h000003, 1'h1);
        br(ADDR_CAUSE, 16'h4000, "uninitialised pointer flag");
        cop(0, 24'h000003, 1'h0);
        cop(1, 24'h000003, 1'h0);
        ev(11'h100, 1'h1);
        cop(1, 24'h000003, 1'h1);
        check(pc_value, RESET_VECTOR, "fetch address");
    endtask

    task automatic t_sec;
        logic [PC_W-1:0] tg [6] = '{24'h001100, 24'h001204, 24'h0012FF,
                                   24'h001000, 24'h001300, 24'h000FFE};
        int k [6] = '{2, 3, 2, 3, 2, 3};
        logic hit [6] = '{1, 1, 1, 0, 0, 0};
        // Window is reloaded each time in case a reset clears it
        for (int i = 0; i < 6; i++)
        begin
            bw(ADDR_SEG_LO, 16'h0010);
            bw(ADDR_SEG_HI, 16'h0012);
            bw(ADDR_PROT_CTRL, 16'h0001);
            cop(k[i], tg[i], hit[i]);
        end
        bw(ADDR_PROT_CTRL, 16'h0000);
        cop(2, 24'h001100, 1'h0);
    endtask

    task automatic t_trap;
        bw(ADDR_CAUSE, 16'h0000);
        bw(ADDR_IRQ_CLR, 16'h000F);
        cop(4, 24'h00000E, 1'h0);
        cop(4, 24'h00000D, 1'h1);
        br(ADDR_CAUSE, 16'h8000, "trap conflict flag");
        br(ADDR_IRQ_STAT, 16'h0005, "trap conflict status");
        cop(4, 24'h00000D, 1'h0);
        cop(5, 24'h000000, 1'h0);
        cop(4, 24'h00000E, 1'h0);
        cop(4, 24'h00000F, 1'h0);
    endtask

    task automatic t_irq;
        bw(ADDR_IRQ_CLR, 16'h000F);
        bw(ADDR_IRQ_EN, 16'h0001);
        bw(ADDR_IRQ_STAT, 16'h000F);
        br(ADDR_IRQ_STAT, 16'h0000, "status is read-only");
        cop(1, 24'h000005, 1'h1);
        tick2();
        check(24'(irq), 24'h000001, "interrupt raised");
        br(ADDR_IRQ_STAT, 16'h0001, "reset status bit");
        bw(ADDR_IRQ_EN, 16'h0000);
        tick2();
        check(24'(irq), 24'h000000, "interrupt masked");
        bw(ADDR_IRQ_CLR, 16'h0001);
        br(ADDR_IRQ_STAT, 16'h0000, "status cleared");
        bw(ADDR_IRQ_EN, 16'h0001);
        tick2();
        check(24'(irq), 24'h000000, "interrupt stays low");
    endtask

    task automatic t_hold;
        bw(ADDR_CAUSE, 16'h0040);
        @(posedge ref_clk);
        ce <= 1'h0;
        // Pin event while disabled must leave no trace
        ev(11'h100, 1'h0);
        @(posedge ref_clk);
        ce <= 1'h1;
        br(ADDR_CAUSE, 16'h0040, "frozen while disabled");
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        br(ADDR_CAUSE, 16'h0040, "flags kept over system reset");
        br(ADDR_IRQ_EN, 16'h0000, "enable cleared by system reset");
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        rst = 1'h1;
        ce = 1'h1;
        bus = '0;
        evt = '0;
        // Power event during reset gives the cause flags a defined start
        evt.por_event = 1'h1;
        asleep = 1'h0;
        @(posedge ref_clk);
        evt <= '0;
        repeat (4) @(posedge ref_clk);
        #1;
        check(24'(pc_load), 24'h000001, "load during reset");
        check(pc_value, RESET_VECTOR, "fetch address in reset");
        @(posedge ref_clk);
        rst <= 1'h0;
        t_power();
        t_events();
        t_wdt();
        t_wreg();
        t_sec();
        t_trap();
        t_irq();
        t_hold();
        final_report();
    end
endmodule
